/* rtl/ddc_top.v */
// DDR input delay control: quarter-period DLL, slave delay, static and dynamic delay taps
//
// Behaviour
// (RULE1) Bypass-lock enabled: skip locking, report lock, code fixed at maximum steps.
// (RULE2) Frequency setting describes reference clock; default 100 MHz, up to 400 MHz.
// (RULE3) Bypass-lock defaults off; applies only at low frequency, selects maximum delay.
// (RULE4) Static line has 32 taps; user mode takes tap count 0..31, default 0.
// (RULE5) Each static tap adds about 105 ps to input data.
// (RULE6) Static mode selector defaults to user-defined; predefined mode recommended.
// (RULE7) Predefined mode follows interface type: zero-hold, SCLK, EDGE_CLOCK, or bypass.
// (RULE8) Static delay only on receive paths; transmit paths get no delay.
// (RULE9) Dynamic line takes 5-bit tap selection from user logic at run time.
// (RULE10) Each dynamic tap adds about 105 ps; only on bottom-side inputs.
// (RULE11) Slave delay shifts received clock by 90 degrees using the code bus.
// (RULE12) New code passes to slaves only while update control is low.
// (RULE13) Freeze high stops the DLL and keeps its code; low resumes.
// (RULE14) Lock stays low from reset until the code settles, then high.
// (RULE15) User logic drives tap selection from one register in its own domain.
//
// Decided for this implementation: the register addresses and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
`include "ddc_consts.vh"

module ddc_top (
  // Clock and reset
  input  wire        clk,
  input  wire        resetn,
  // Register port
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  // DLL controls from user logic
  input  wire        dll_freeze,
  input  wire        code_update_n,
  // Dynamic tap selection from user logic
  input  wire [4:0]  tap_select_bits,
  // DLL outputs
  output reg         dll_lock,
  output reg  [7:0]  delay_code_bus,
  // Clock slave delay setting
  output reg  [7:0]  slave_delay_code,
  // Data delay settings
  output reg  [4:0]  static_tap,
  output reg         static_delay_en,
  output reg  [4:0]  dynamic_tap,
  output reg         dynamic_delay_en
);

  localparam [31:0] STEP_CYC  = `DDC_STEP_CYC;
  localparam [7:0]  STEP_LAST = STEP_CYC[7:0] - 8'h01;

  // Configuration registers
  reg        bypass_lock;
  reg        lock_sens_high;
  reg        dll_soft_rst;
  reg [9:0]  dll_freq_setting;
  reg        delay_mode_sel;
  reg [4:0]  delay_tap_count;
  reg [3:0]  iface_type;
  reg        bottom_side;

  // DLL state
  reg [7:0]  dll_code;
  reg [3:0]  settle_cnt;
  reg [7:0]  step_cnt;
  reg        step_tick;
  reg        lock_int;

  // Synchronised user inputs
  wire       freeze_s;
  wire       update_n_s;
  wire [4:0] tap_sel_s;

  // Static path decode
  reg [2:0]  next_mode;
  reg [4:0]  next_static_tap;
  reg        next_static_en;

  wire wr_ctrl   = reg_wr && (reg_addr == `DDC_REG_CTRL);
  wire wr_freq   = reg_wr && (reg_addr == `DDC_REG_FREQ);
  wire wr_static = reg_wr && (reg_addr == `DDC_REG_STATIC);
  wire freq_ok   = (reg_wdata[9:0] >= `DDC_FREQ_MIN) && (reg_wdata[9:0] <= `DDC_FREQ_MAX)
                   && (reg_wdata[31:10] == 22'h000000);
  wire freq_take = wr_freq && freq_ok;
  wire cfg_change = freq_take
                    || (wr_ctrl && (reg_wdata[`DDC_CTRL_BYPASS] != bypass_lock));

  // Forcing only makes sense for slow reference clocks
  wire force_max = bypass_lock && (dll_freq_setting <= `DDC_FORCE_FMAX); // (RULE3)

  // Synchronisers for signals from the user clock domain
  ddc_sync #(.W(1), .INIT(1'b0)) u_sync_freeze (
    .clk    (clk),
    .resetn (resetn),
    .din    (dll_freeze),
    .dout   (freeze_s)
  );

  ddc_sync #(.W(1), .INIT(1'b1)) u_sync_update (
    .clk    (clk),
    .resetn (resetn),
    .din    (code_update_n),
    .dout   (update_n_s)
  );

  // Bus is taken only when two successive samples of all five bits agree
  ddc_sync #(.W(5), .INIT(5'h00)) u_sync_tap (
    .clk    (clk),
    .resetn (resetn),
    .din    (tap_select_bits), // (RULE15)
    .dout   (tap_sel_s)
  );

  // Register writes
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bypass_lock      <= `DDC_RST_BYPASS; // (RULE3)
      lock_sens_high   <= `DDC_RST_SENS;
      dll_soft_rst     <= 1'b0;
      dll_freq_setting <= `DDC_RST_FREQ; // (RULE2)
      delay_mode_sel   <= `DDC_RST_MODE; // (RULE6)
      delay_tap_count  <= `DDC_RST_TAP; // (RULE4)
      iface_type       <= `DDC_RST_IFACE;
      bottom_side      <= `DDC_RST_BOTTOM;
    end else begin
      if (wr_ctrl) begin
        bypass_lock    <= reg_wdata[`DDC_CTRL_BYPASS];
        lock_sens_high <= reg_wdata[`DDC_CTRL_SENS];
        dll_soft_rst   <= reg_wdata[`DDC_CTRL_SRST];
      end
      // Out-of-range settings are dropped, old value kept
      if (freq_take) begin
        dll_freq_setting <= reg_wdata[9:0]; // (RULE2)
      end
      if (wr_static) begin
        delay_mode_sel  <= reg_wdata[`DDC_ST_MODE];
        delay_tap_count <= reg_wdata[`DDC_ST_TAP_MSB:`DDC_ST_TAP_LSB]; // (RULE4)
        iface_type      <= reg_wdata[`DDC_ST_IF_MSB:`DDC_ST_IF_LSB];
        bottom_side     <= reg_wdata[`DDC_ST_BOTTOM];
      end
    end
  end

  // Step-rate divider for the tracking loop
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      step_cnt  <= 8'h00;
      step_tick <= 1'b0;
    end else begin
      if (step_cnt == STEP_LAST) begin
        step_cnt  <= 8'h00;
        step_tick <= 1'b1;
      end else begin
        step_cnt  <= step_cnt + 8'h01;
        step_tick <= 1'b0;
      end
    end
  end

  // Quarter-period search: code*105ps*f compared with 1e6/4 ps*MHz
  wire [25:0] code_ext = {18'h00000, dll_code};
  wire [25:0] freq_ext = {16'h0000, dll_freq_setting};
  wire [25:0] prod_cur = code_ext * freq_ext * `DDC_TAP_PS;
  wire [25:0] prod_up  = (code_ext + 26'd1) * freq_ext * `DDC_TAP_PS;
  wire        go_up    = (prod_up <= `DDC_QUARTER_PS_MHZ) && (dll_code != `DDC_CODE_MAX);
  wire        go_down  = (prod_cur > `DDC_QUARTER_PS_MHZ) && (dll_code != 8'h00);

  // Master DLL tracking and lock
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dll_code   <= 8'h00;
      settle_cnt <= 4'h0;
      lock_int   <= 1'b0; // (RULE14)
    end else if (dll_soft_rst) begin
      dll_code   <= 8'h00;
      settle_cnt <= 4'h0;
      lock_int   <= 1'b0; // (RULE14)
    end else if (cfg_change) begin
      // New reference clock or bypass change: lock must be earned again
      settle_cnt <= 4'h0;
      lock_int   <= 1'b0; // (RULE14)
    end else if (freeze_s) begin
      // Frozen: code and lock held as they are
      dll_code   <= dll_code; // (RULE13)
    end else if (step_tick) begin
      if (force_max) begin
        dll_code   <= `DDC_CODE_MAX; // (RULE1)
        lock_int   <= 1'b1; // (RULE1)
        settle_cnt <= 4'h0;
      end else if (go_up || go_down) begin
        if (go_up) begin
          dll_code <= dll_code + 8'h01;
        end else begin
          dll_code <= dll_code - 8'h01;
        end
        settle_cnt <= 4'h0;
        // Low sensitivity rides through a jitter step once locked
        if (lock_sens_high) begin
          lock_int <= 1'b0;
        end
      end else if (settle_cnt != `DDC_SETTLE_TICKS) begin
        settle_cnt <= settle_cnt + 4'h1;
      end else begin
        lock_int <= 1'b1; // (RULE14)
      end
    end
  end

  // Code bus to slaves, lock and slave delay setting
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      delay_code_bus   <= 8'h00;
      dll_lock         <= 1'b0;
      slave_delay_code <= 8'h00;
    end else begin
      // Hold while update is high so transfers never see a code step
      if (!update_n_s) begin
        delay_code_bus <= dll_code; // (RULE12)
      end
      dll_lock         <= lock_int; // (RULE14)
      // Slave cell applies the quarter-period code to the received clock
      slave_delay_code <= delay_code_bus; // (RULE11)
    end
  end

  // Static delay mode resolution
  always @* begin
    next_mode       = `DDC_EM_NONE;
    next_static_tap = 5'h00;
    next_static_en  = 1'b0;
    if (iface_type >= `DDC_IF_TX_FIRST) begin
      // Transmit: no delay mode at all
      next_mode = `DDC_EM_NONE; // (RULE8)
    end else if (delay_mode_sel == `DDC_SEL_USER) begin
      next_mode       = `DDC_EM_USER;
      next_static_tap = delay_tap_count; // (RULE4)
      next_static_en  = 1'b1;
    end else begin
      case (iface_type) // (RULE7)
        `DDC_IF_GIREG_RX: begin
          next_mode       = `DDC_EM_ZEROHOLD;
          next_static_tap = `DDC_TAP_ZEROHOLD;
          next_static_en  = 1'b1;
        end
        `DDC_IF_X1_AL: begin
          next_mode       = `DDC_EM_SCLK_AL;
          next_static_tap = `DDC_TAP_SCLK_AL;
          next_static_en  = 1'b1;
        end
        `DDC_IF_X1_CE: begin
          next_mode       = `DDC_EM_SCLK_CE;
          next_static_tap = `DDC_TAP_SCLK_CE;
          next_static_en  = 1'b1;
        end
        `DDC_IF_X2_AL, `DDC_IF_X4_AL: begin
          next_mode       = `DDC_EM_EDGE_CLOCK_AL;
          next_static_tap = `DDC_TAP_EDGE_CLOCK_AL;
          next_static_en  = 1'b1;
        end
        `DDC_IF_X2_CE, `DDC_IF_X4_CE: begin
          next_mode       = `DDC_EM_EDGE_CLOCK_CE;
          next_static_tap = `DDC_TAP_EDGE_CLOCK_CE;
          next_static_en  = 1'b1;
        end
        default: begin
          next_mode       = `DDC_EM_BYPASS;
          next_static_tap = 5'h00;
          next_static_en  = 1'b0;
        end
      endcase
    end
  end

  reg [2:0] eff_mode;

  // Data delay outputs
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      eff_mode         <= `DDC_EM_ZEROHOLD;
      static_tap       <= 5'h00;
      static_delay_en  <= 1'b0;
      dynamic_tap      <= 5'h00;
      dynamic_delay_en <= 1'b0;
    end else begin
      eff_mode        <= next_mode; // (RULE7)
      static_tap      <= next_static_tap; // (RULE5)
      static_delay_en <= next_static_en; // (RULE8)
      // Dynamic line exists only on bottom-side inputs
      if (bottom_side) begin
        dynamic_tap      <= tap_sel_s; // (RULE9)
        dynamic_delay_en <= 1'b1; // (RULE10)
      end else begin
        dynamic_tap      <= 5'h00; // (RULE10)
        dynamic_delay_en <= 1'b0;
      end
    end
  end

  // Delay in picoseconds for software, 105 ps per tap
  wire [15:0] static_ps  = {11'h000, static_tap} * `DDC_TAP_PS16; // (RULE5)
  wire [15:0] dynamic_ps = {11'h000, dynamic_tap} * `DDC_TAP_PS16; // (RULE10)

  // Register reads, data valid one cycle after the strobe
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      if (reg_addr == `DDC_REG_CTRL) begin
        reg_rdata <= {29'h00000000, dll_soft_rst, lock_sens_high, bypass_lock};
      end else if (reg_addr == `DDC_REG_FREQ) begin
        reg_rdata <= {22'h000000, dll_freq_setting};
      end else if (reg_addr == `DDC_REG_STATIC) begin
        reg_rdata <= {15'h0000, bottom_side, iface_type, 3'h0, delay_tap_count,
                      3'h0, delay_mode_sel};
      end else if (reg_addr == `DDC_REG_STATUS) begin
        reg_rdata <= {8'h00, delay_code_bus, dll_code, 5'h00, force_max, freeze_s,
                      dll_lock};
      end else if (reg_addr == `DDC_REG_TAPS) begin
        reg_rdata <= {13'h0000, eff_mode, 2'h0, dynamic_delay_en, dynamic_tap,
                      2'h0, static_delay_en, static_tap};
      end else if (reg_addr == `DDC_REG_DELAY_PS) begin
        reg_rdata <= {dynamic_ps, static_ps};
      end else begin
        reg_rdata <= 32'h00000000;
      end
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

endmodule // ddc_top

`default_nettype wire

/* rtl/ddc_consts.vh */
// Constants for the DDR input delay control block
`ifndef DDC_CONSTS_VH
`define DDC_CONSTS_VH

// Register offsets (byte addresses)
`define DDC_REG_CTRL        8'h00
`define DDC_REG_FREQ        8'h04
`define DDC_REG_STATIC      8'h08
`define DDC_REG_STATUS      8'h0C
`define DDC_REG_TAPS        8'h10
`define DDC_REG_DELAY_PS    8'h14

// Control register fields
`define DDC_CTRL_BYPASS     0
`define DDC_CTRL_SENS       1
`define DDC_CTRL_SRST       2

// Static register fields
`define DDC_ST_MODE         0
`define DDC_ST_TAP_LSB      4
`define DDC_ST_TAP_MSB      8
`define DDC_ST_IF_LSB       12
`define DDC_ST_IF_MSB       15
`define DDC_ST_BOTTOM       16

// Reset values
`define DDC_RST_BYPASS      1'b0
`define DDC_RST_SENS        1'b0
`define DDC_RST_FREQ        10'h064
`define DDC_RST_MODE        1'b0
`define DDC_RST_TAP         5'h00
`define DDC_RST_IFACE       4'h0
`define DDC_RST_BOTTOM      1'b1

// Frequency setting limits in MHz
`define DDC_FREQ_MIN        10'h001
`define DDC_FREQ_MAX        10'h190
`define DDC_FORCE_FMAX      10'h032

// Delay code
`define DDC_CODE_W          8
`define DDC_CODE_MAX        8'hFF
`define DDC_TAP_PS          26'd105
`define DDC_TAP_PS16        16'd105
`define DDC_PERIOD_PS_MHZ   26'd1000000
`define DDC_QUARTER_PS_MHZ  (`DDC_PERIOD_PS_MHZ / 26'd4)

// Timing
`define DDC_CLK_NS          20
`define DDC_STEP_NS         320
`define DDC_STEP_CYC        ((`DDC_STEP_NS + `DDC_CLK_NS - 1) / `DDC_CLK_NS)
`define DDC_SETTLE_TICKS    4'h8

// Delay mode select
`define DDC_SEL_USER        1'b0
`define DDC_SEL_PREDEF      1'b1

// Receive interface types, then the first transmit type
`define DDC_IF_GIREG_RX     4'h0
`define DDC_IF_X1_AL        4'h1
`define DDC_IF_X1_CE        4'h2
`define DDC_IF_X2_AL        4'h3
`define DDC_IF_X2_CE        4'h4
`define DDC_IF_X4_AL        4'h5
`define DDC_IF_X4_CE        4'h6
`define DDC_IF_X71          4'h7
`define DDC_IF_TX_FIRST     4'h8

// Effective delay modes
`define DDC_EM_NONE         3'h0
`define DDC_EM_ZEROHOLD     3'h1
`define DDC_EM_SCLK_AL      3'h2
`define DDC_EM_SCLK_CE      3'h3
`define DDC_EM_EDGE_CLOCK_AL      3'h4
`define DDC_EM_EDGE_CLOCK_CE      3'h5
`define DDC_EM_BYPASS       3'h6
`define DDC_EM_USER         3'h7

// Predefined tap counts per mode
`define DDC_TAP_ZEROHOLD    5'h0C
`define DDC_TAP_SCLK_AL     5'h04
`define DDC_TAP_SCLK_CE     5'h00
`define DDC_TAP_EDGE_CLOCK_AL     5'h08
`define DDC_TAP_EDGE_CLOCK_CE     5'h00

`endif

/* rtl/ddc_sync.v */
// Three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none

module ddc_sync #(
  parameter       W   = 1,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  // Clock and reset
  input  wire         clk,
  input  wire         resetn,
  // Asynchronous input
  input  wire [W-1:0] din,
  // Filtered output
  output reg  [W-1:0] dout
);

  reg [W-1:0] s1;
  reg [W-1:0] s2;
  reg [W-1:0] s3;

  // Whole word moves at once, so a skewed bus never shows a mixed value
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s1   <= INIT;
      s2   <= INIT;
      s3   <= INIT;
      dout <= INIT;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        dout <= s3;
      end
    end
  end

endmodule // ddc_sync

`default_nettype wire

/* sim/ddc_checker.sv */
// Port assertions for the DDR input delay control block
`timescale 1ns/10ps
`default_nettype none
module ddc_checker (
  // Clock and reset
  input wire logic        clk,
  input wire logic        resetn,
  // Register port
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  // User controls
  input wire logic        dll_freeze,
  input wire logic        code_update_n,
  input wire logic [4:0]  tap_select_bits,
  // Delay outputs
  input wire logic        dll_lock,
  input wire logic [7:0]  delay_code_bus,
  input wire logic [7:0]  slave_delay_code,
  input wire logic [4:0]  static_tap,
  input wire logic        static_delay_en,
  input wire logic [4:0]  dynamic_tap,
  input wire logic        dynamic_delay_en
);
  logic [3:0] upd_age;
  logic [3:0] upd_low;
  logic [3:0] frz_cnt;
  // Saturating counts; bounds allow for the input synchroniser delay
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      upd_age <= 4'hF;
      upd_low <= 4'h0;
      frz_cnt <= 4'h0;
    end else begin
      upd_age <= !code_update_n ? 4'h0 : upd_age + {3'h0, upd_age != 4'hF};
      upd_low <= code_update_n ? 4'h0 : upd_low + {3'h0, upd_low != 4'hF};
      frz_cnt <= !dll_freeze ? 4'h0 : frz_cnt + {3'h0, frz_cnt != 4'hF};
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_dyn_quiet;
    dynamic_delay_en && $stable(tap_select_bits);
  endsequence
  sequence s_dyn_off;
    !dynamic_delay_en ##1 !dynamic_delay_en;
  endsequence
  property p_code_hold;
    $changed(delay_code_bus) |-> upd_age <= 4'h8;
  endproperty
  a_code_hold: assert property (p_code_hold) else $error("code moved on hold");
  property p_slave;
    $changed(delay_code_bus) |=> slave_delay_code == $past(delay_code_bus);
  endproperty
  a_slave: assert property (p_slave) else $error("slave code lags");
  property p_lock_cold;
    $rose(resetn) |-> !dll_lock [*3];
  endproperty
  a_lock_cold: assert property (p_lock_cold) else $error("early lock");
  property p_dyn_zero;
    s_dyn_off |-> $past(dynamic_tap) == 5'h00;
  endproperty
  a_dyn_zero: assert property (p_dyn_zero) else $error("tap off side");
  property p_dyn_follow;
    s_dyn_quiet [*7] |-> dynamic_tap == tap_select_bits;
  endproperty
  a_dyn_follow: assert property (p_dyn_follow) else $error("tap not taken");
  property p_static_off;
    !static_delay_en |-> static_tap == 5'h00;
  endproperty
  a_static_off: assert property (p_static_off) else $error("tap while off");
  property p_frozen;
    frz_cnt >= 4'h8 && upd_low >= 4'h8 |-> $stable(delay_code_bus);
  endproperty
  a_frozen: assert property (p_frozen) else $error("code moved frozen");
  property p_rdata_idle;
    !$past(reg_rd) |-> reg_rdata == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("stray read data");
endmodule // ddc_checker
bind ddc_top ddc_checker u_ddc_checker (.clk(clk), .resetn(resetn), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .dll_freeze(dll_freeze), .code_update_n(code_update_n),
  .tap_select_bits(tap_select_bits), .dll_lock(dll_lock), .delay_code_bus(delay_code_bus),
  .slave_delay_code(slave_delay_code), .static_tap(static_tap),
  .static_delay_en(static_delay_en), .dynamic_tap(dynamic_tap),
  .dynamic_delay_en(dynamic_delay_en));
`default_nettype wire

/* sim/ddc_user_logic.sv */
// Fabric user logic model driving DLL and dynamic tap controls
`timescale 1ns/10ps
`default_nettype none
module ddc_user_logic (
  // Clock and reset
  input wire logic       clk,
  input wire logic       resetn,
  // Requests from the bench
  input wire logic [4:0] want_tap,
  input wire logic       want_freeze,
  input wire logic       want_update,
  // Controls toward the block
  output logic           dll_freeze,
  output logic           code_update_n,
  output logic [4:0]     tap_select_bits
);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dll_freeze      <= 1'b0;
      code_update_n   <= 1'b1;
      tap_select_bits <= 5'h00;
    end else begin
      // One register, so the five bits never skew apart
      tap_select_bits <= want_tap;
      // Opened whenever the bench requests it, with no check against register accesses
      code_update_n   <= !want_update;
      // Clock never stops here, so freeze may toggle freely
      dll_freeze      <= want_freeze;
    end
  end
endmodule // ddc_user_logic
`default_nettype wire

/* sim/ddr_input_delay_control_test.sv */
// Self-checking bench for the DDR input delay control block
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin miscompares++; \
  $display("wrong value at %0t: got %h expected %h", $time, (a), (e)); end end
module ddr_input_delay_control_test;
  logic        clk, resetn, reg_wr, reg_rd, want_freeze, want_update;
  logic        dll_freeze, code_update_n, dll_lock, static_delay_en, dynamic_delay_en;
  logic [7:0]  reg_addr, delay_code_bus, slave_delay_code;
  logic [31:0] reg_wdata, reg_rdata, rv, seed;
  logic [4:0]  want_tap, tap_select_bits, static_tap, dynamic_tap;
  integer      miscompares = 0, cmp_count = 0, i, n, t, byp;

  ddc_top u_ddc_top (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dll_freeze(dll_freeze),
    .code_update_n(code_update_n), .tap_select_bits(tap_select_bits), .dll_lock(dll_lock),
    .delay_code_bus(delay_code_bus), .slave_delay_code(slave_delay_code),
    .static_tap(static_tap), .static_delay_en(static_delay_en), .dynamic_tap(dynamic_tap),
    .dynamic_delay_en(dynamic_delay_en));
  ddc_user_logic u_ddc_user_logic (.clk(clk), .resetn(resetn), .want_tap(want_tap),
    .want_freeze(want_freeze), .want_update(want_update), .dll_freeze(dll_freeze),
    .code_update_n(code_update_n), .tap_select_bits(tap_select_bits));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  function logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction
  // Reference: largest code whose delay fits a quarter period, or 255 under bypass at 50 MHz or below
  function integer code_of(input integer fm);
    if (byp != 0 && fm <= 50) code_of = 255;
    else code_of = (250000 / (105 * fm) > 255) ? 255 : 250000 / (105 * fm);
  endfunction
  function integer ptap(input integer k);
    case (k)
      0: ptap = 12;
      1: ptap = 4;
      3, 5: ptap = 8;
      default: ptap = 0;
    endcase
  endfunction
  function integer emode(input integer k);
    case (k)
      0: emode = 1;
      1: emode = 2;
      2: emode = 3;
      3, 5: emode = 4;
      4, 6: emode = 5;
      7: emode = 6;
      default: emode = 0;
    endcase
  endfunction
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    @(negedge clk);
    rv = reg_rdata;
  endtask
  task lock_wait;
    repeat (4) @(posedge clk);
    n = 0;
    while (dll_lock !== 1'b1 && n < 6000) begin
      @(posedge clk);
      n = n + 1;
    end
    repeat (8) @(posedge clk);
  endtask
  task give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #1000000;
    miscompares++;
    give_verdict;
  end
  initial begin
    resetn = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    want_tap = 5'h00;
    want_freeze = 1'b0;
    want_update = 1'b1;
    seed = 32'hFA4C;
    byp = 0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    rd(8'h04);
    `CHK(rv, 32'h64)
    rd(8'h00);
    `CHK(rv, 32'h0)
    rd(8'h08);
    `CHK(rv, 32'h10000)
    rd(8'h18);
    `CHK(rv, 32'h0)
    $display("reset test done");
    for (i = 0; i < 16; i++) begin
      wr(8'h08, 32'h10001 | (i << 12));
      repeat (3) @(posedge clk);
      `CHK({static_delay_en, static_tap}, i > 6 ? 0 : 32 + ptap(i))
      rd(8'h10);
      `CHK(rv[18:16], emode(i))
    end
    for (i = 0; i < 4; i++) begin
      seed = xs(seed);
      t = i == 0 ? 31 : seed[4:0];
      wr(8'h08, 32'h10000 | (t << 4));
      repeat (3) @(posedge clk);
      `CHK({static_delay_en, static_tap}, 32 + t)
      rd(8'h14);
      `CHK(rv[15:0], t * 105)
    end
    $display("static test done");
    lock_wait;
    `CHK(dll_lock, 1'b1)
    `CHK(slave_delay_code, code_of(100))
    want_update <= 1'b0;
    repeat (6) @(posedge clk);
    wr(8'h04, 32'd400);
    lock_wait;
    rd(8'h0C);
    `CHK(rv[15:8], code_of(400))
    `CHK(delay_code_bus, code_of(100))
    want_update <= 1'b1;
    repeat (8) @(posedge clk);
    `CHK(delay_code_bus, code_of(400))
    want_freeze <= 1'b1;
    repeat (8) @(posedge clk);
    wr(8'h04, 32'd200);
    repeat (100) @(posedge clk);
    rd(8'h0C);
    `CHK(rv[1:0], 2'b10)
    `CHK(rv[15:8], code_of(400))
    want_freeze <= 1'b0;
    lock_wait;
    `CHK(delay_code_bus, code_of(200))
    wr(8'h04, 32'd0);
    wr(8'h04, 32'd401);
    wr(8'h04, 32'h464);
    rd(8'h04);
    `CHK(rv, 32'hC8)
    $display("dll test done");
    byp = 1;
    wr(8'h00, 32'h1);
    wr(8'h04, 32'd50);
    lock_wait;
    `CHK(delay_code_bus, code_of(50))
    rd(8'h0C);
    `CHK(rv[2:0], 3'h5)
    wr(8'h04, 32'd51);
    lock_wait;
    `CHK(delay_code_bus, code_of(51))
    wr(8'h00, 32'h0);
    byp = 0;
    $display("bypass test done");
    for (i = 0; i < 8; i++) begin
      seed = xs(seed);
      t = i == 0 ? 31 : seed[4:0];
      want_tap <= t[4:0];
      repeat (8) @(posedge clk);
      `CHK(dynamic_tap, t[4:0])
      rd(8'h14);
      `CHK(rv[31:16], t * 105)
    end
    wr(8'h08, 32'h0);
    repeat (8) @(posedge clk);
    `CHK({dynamic_delay_en, dynamic_tap}, 6'h00)
    $display("dynamic test done");
    wr(8'h00, 32'h6);
    repeat (4) @(posedge clk);
    rd(8'h00);
    `CHK(rv, 32'h6)
    rd(8'h0C);
    `CHK(rv[15:0], 16'h0000)
    wr(8'h00, 32'h0);
    lock_wait;
    `CHK(dll_lock, 1'b1)
    `CHK(delay_code_bus, code_of(51))
    $display("soft reset test done");
    give_verdict;
  end
endmodule // ddr_input_delay_control_test
`default_nettype wire
